// *** verilog/p2s_pkg.sv ***
// constants, field layouts and carrier types for the port 2 strap default block
// assumes one 200 MHz clock, synchronous active-low reset and a 32-bit apb master
package p2s_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_STRAP      = 8'h00;
  localparam logic [7:0] OFS_FLOW       = 8'h04;
  localparam logic [7:0] OFS_MAC_TX_CFG = 8'h08;
  localparam logic [7:0] OFS_PHY_ADV    = 8'h0C;
  localparam logic [7:0] OFS_PHY_EEE    = 8'h10;

  // manual flow register fields
  localparam int unsigned FLOW_BP_POS  = 0;
  localparam int unsigned FLOW_TX_POS  = 1;
  localparam int unsigned FLOW_RX_POS  = 2;
  localparam int unsigned FLOW_MAN_POS = 3;
  localparam int unsigned FLOW_W       = 4;

  // mac transmit config field
  localparam int unsigned MAC_EEE_POS = 0;
  localparam int unsigned MAC_W       = 1;

  // phy advertisement fields
  localparam int unsigned ADV_SYM_POS  = 0;
  localparam int unsigned ADV_ASYM_POS = 1;
  localparam int unsigned ADV_W        = 2;

  // phy eee fields, capability is read only
  localparam int unsigned EEE_EN_POS  = 0;
  localparam int unsigned EEE_CAP_POS = 1;
  localparam int unsigned EEE_ADV_POS = 2;
  localparam int unsigned EEE_W       = 3;

  // strap readback fields
  localparam int unsigned STR_BP_POS    = 0;
  localparam int unsigned STR_FD_POS    = 1;
  localparam int unsigned STR_MAN_POS   = 2;
  localparam int unsigned STR_EEE_POS   = 3;
  localparam int unsigned STR_FIBER_POS = 4;
  localparam int unsigned STR_DONE_POS  = 5;

  // strap defaults when nothing drives them
  localparam logic STRAP_BP_DFLT  = 1'b1;
  localparam logic STRAP_FD_DFLT  = 1'b1;
  localparam logic STRAP_MAN_DFLT = 1'b0;

  // register values before straps are loaded, and the phy eee write mask
  localparam logic [FLOW_W-1:0] FLOW_RST = 4'h0;
  localparam logic [MAC_W-1:0]  MAC_RST  = 1'h0;
  localparam logic [ADV_W-1:0]  ADV_RST  = 2'h0;
  localparam logic [EEE_W-1:0]  EEE_RST  = 3'h0;
  localparam logic [EEE_W-1:0]  EEE_WMASK = 3'h5;

  typedef struct packed {
    logic backpressure;
    logic fullduplex_pause;
    logic manual_pause;
  } p2s_straps_t;

  typedef struct packed {
    logic manual_pause_ctrl;
    logic rx_pause_enable;
    logic tx_pause_enable;
    logic backpressure_enable;
  } p2s_flow_t;

  typedef struct packed {
    logic advertise;
    logic capability;
    logic enable;
  } p2s_phy_eee_t;

  typedef struct packed {
    logic asym_pause;
    logic sym_pause;
  } p2s_phy_adv_t;

endpackage : p2s_pkg

// *** verilog/p2s_cfg_reg.sv ***
// one strap-defaulted configuration register
// assumes load and write never needed in the same cycle; load wins
module p2s_cfg_reg #(
  parameter int unsigned     W     = 1,
  parameter logic [W-1:0]    RST   = '0,
  parameter logic [W-1:0]    WMASK = '1
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_val_in,
  input  wire logic         wr_in,
  input  wire logic [W-1:0] wr_data_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] q_r;

  // strap load first, then software writes on writable bits
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      q_r <= RST;
    end else if (load_in) begin
      q_r <= load_val_in;
    end else if (wr_in) begin
      q_r <= (q_r & ~WMASK) | (wr_data_in & WMASK);
    end
  end

  assign q_out = q_r;

endmodule // p2s_cfg_reg

// *** verilog/p2s_top.sv ***
// port 2 strap default loader with apb register access
// assumes strap levels and fiber mode stable through reset release
//
// Our own choices: the APB slave port and the register offsets.
module p2s_top (
  input  wire logic                        ref_clk_in,
  input  wire logic                        rst_n_in,
  input  wire p2s_pkg::p2s_straps_t        straps_in,
  input  wire logic                        energy_efficient_enable_pin_in,
  input  wire logic                        phy_b_fiber_mode_in,
  input  wire logic                        psel_in,
  input  wire logic                        penable_in,
  input  wire logic                        pwrite_in,
  input  wire logic [p2s_pkg::ADDR_W-1:0]  paddr_in,
  input  wire logic [p2s_pkg::DATA_W-1:0]  pwdata_in,
  output logic                             pready_out,
  output logic                             pslverr_out,
  output logic      [p2s_pkg::DATA_W-1:0]  prdata_out,
  output p2s_pkg::p2s_flow_t               port2_flow_out,
  output logic                             mac_energy_efficient_enable_out,
  output p2s_pkg::p2s_phy_adv_t            phy_autoneg_advertise_out,
  output p2s_pkg::p2s_phy_eee_t            phy_energy_efficient_out,
  output logic                             straps_loaded_out
);
  import p2s_pkg::*;

  // captured strap state
  p2s_straps_t              strap_r;
  logic                     eee_strap_r;
  logic                     fiber_r;
  logic                     loaded_r;
  logic                     load_pulse;

  // derived defaults
  logic [FLOW_W-1:0]        flow_dflt;
  logic [MAC_W-1:0]         mac_dflt;
  logic [ADV_W-1:0]         adv_dflt;
  logic [EEE_W-1:0]         eee_dflt;

  // register contents
  logic [FLOW_W-1:0]        flow_q;
  logic [MAC_W-1:0]         mac_q;
  logic [ADV_W-1:0]         adv_q;
  logic [EEE_W-1:0]         eee_q;

  // bus decode
  logic                     access;
  logic                     wr_done;
  logic                     wr_flow;
  logic                     wr_mac;
  logic                     wr_adv;
  logic                     wr_eee;
  logic                     mapped;
  logic [DATA_W-1:0]        rd_nxt;
  logic [DATA_W-1:0]        strap_word;

  // output flops
  logic                     pready_r;
  logic                     pslverr_r;
  logic [DATA_W-1:0]        prdata_r;
  p2s_flow_t                flow_out_r;
  logic                     mac_out_r;
  p2s_phy_adv_t             adv_out_r;
  p2s_phy_eee_t             eee_out_r;

  // one load, on the first edge after reset release
  assign load_pulse = !loaded_r;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      loaded_r <= 1'b0;
    end else begin
      loaded_r <= 1'b1;
    end
  end

  // strap capture, held until the next reset
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      strap_r.backpressure     <= STRAP_BP_DFLT;
      strap_r.fullduplex_pause <= STRAP_FD_DFLT;
      strap_r.manual_pause     <= STRAP_MAN_DFLT;
    end else if (load_pulse) begin
      strap_r <= straps_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      eee_strap_r <= 1'b0;
    end else if (load_pulse) begin
      eee_strap_r <= energy_efficient_enable_pin_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      fiber_r <= 1'b0;
    end else if (load_pulse) begin
      fiber_r <= phy_b_fiber_mode_in;
    end
  end

  // switch-side flow defaults
  always_comb begin
    flow_dflt               = FLOW_RST;
    flow_dflt[FLOW_BP_POS]  = straps_in.backpressure;
    flow_dflt[FLOW_TX_POS]  = straps_in.fullduplex_pause;
    flow_dflt[FLOW_RX_POS]  = straps_in.fullduplex_pause;
    flow_dflt[FLOW_MAN_POS] = straps_in.manual_pause;
  end

  // mac eee default, off in fiber mode
  always_comb begin
    mac_dflt              = MAC_RST;
    mac_dflt[MAC_EEE_POS] = energy_efficient_enable_pin_in & !phy_b_fiber_mode_in;
  end

  // phy pause advertisement defaults
  always_comb begin
    adv_dflt = ADV_RST;
    if (!phy_b_fiber_mode_in) begin
      if (straps_in.manual_pause) begin
        adv_dflt[ADV_SYM_POS]  = straps_in.fullduplex_pause;
        adv_dflt[ADV_ASYM_POS] = 1'b0;
      end else begin
        adv_dflt[ADV_SYM_POS]  = straps_in.fullduplex_pause;
        adv_dflt[ADV_ASYM_POS] = straps_in.fullduplex_pause;
      end
    end
  end

  // phy eee defaults
  always_comb begin
    eee_dflt = EEE_RST;
    if (!phy_b_fiber_mode_in) begin
      eee_dflt[EEE_EN_POS]  = energy_efficient_enable_pin_in;
      eee_dflt[EEE_CAP_POS] = energy_efficient_enable_pin_in;
      eee_dflt[EEE_ADV_POS] = energy_efficient_enable_pin_in;
    end
  end

  // apb decode, write lands at the edge that sees pready
  assign access  = psel_in & penable_in;
  assign wr_done = access & pready_r & pwrite_in;

  always_comb begin
    wr_flow = 1'b0;
    wr_mac  = 1'b0;
    wr_adv  = 1'b0;
    wr_eee  = 1'b0;
    mapped  = 1'b1;
    if (paddr_in == OFS_STRAP) begin
      mapped = !pwrite_in;
    end else if (paddr_in == OFS_FLOW) begin
      wr_flow = wr_done;
    end else if (paddr_in == OFS_MAC_TX_CFG) begin
      wr_mac = wr_done;
    end else if (paddr_in == OFS_PHY_ADV) begin
      wr_adv = wr_done;
    end else if (paddr_in == OFS_PHY_EEE) begin
      wr_eee = wr_done;
    end else begin
      mapped = 1'b0;
    end
  end

  // strap readback word
  always_comb begin
    strap_word                = '0;
    strap_word[STR_BP_POS]    = strap_r.backpressure;
    strap_word[STR_FD_POS]    = strap_r.fullduplex_pause;
    strap_word[STR_MAN_POS]   = strap_r.manual_pause;
    strap_word[STR_EEE_POS]   = eee_strap_r;
    strap_word[STR_FIBER_POS] = fiber_r;
    strap_word[STR_DONE_POS]  = loaded_r;
  end

  // read mux
  always_comb begin
    rd_nxt = '0;
    if (paddr_in == OFS_STRAP) begin
      rd_nxt = strap_word;
    end else if (paddr_in == OFS_FLOW) begin
      rd_nxt[FLOW_W-1:0] = flow_q;
    end else if (paddr_in == OFS_MAC_TX_CFG) begin
      rd_nxt[MAC_W-1:0] = mac_q;
    end else if (paddr_in == OFS_PHY_ADV) begin
      rd_nxt[ADV_W-1:0] = adv_q;
    end else if (paddr_in == OFS_PHY_EEE) begin
      rd_nxt[EEE_W-1:0] = eee_q;
    end
  end

  // one wait state per access
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= access & !pready_r;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pslverr_r <= 1'b0;
    end else if (access & !pready_r) begin
      pslverr_r <= !mapped;
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  // read data only alongside pready
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      prdata_r <= '0;
    end else if (access & !pready_r) begin
      prdata_r <= pwrite_in ? '0 : rd_nxt;
    end else begin
      prdata_r <= '0;
    end
  end

  // configuration registers
  p2s_cfg_reg #(.W(FLOW_W), .RST(FLOW_RST)) u_flow (
    .ref_clk_in  (ref_clk_in),
    .rst_n_in    (rst_n_in),
    .load_in     (load_pulse),
    .load_val_in (flow_dflt),
    .wr_in       (wr_flow),
    .wr_data_in  (pwdata_in[FLOW_W-1:0]),
    .q_out       (flow_q)
  );

  p2s_cfg_reg #(.W(MAC_W), .RST(MAC_RST)) u_mac (
    .ref_clk_in  (ref_clk_in),
    .rst_n_in    (rst_n_in),
    .load_in     (load_pulse),
    .load_val_in (mac_dflt),
    .wr_in       (wr_mac),
    .wr_data_in  (pwdata_in[MAC_W-1:0]),
    .q_out       (mac_q)
  );

  p2s_cfg_reg #(.W(ADV_W), .RST(ADV_RST)) u_adv (
    .ref_clk_in  (ref_clk_in),
    .rst_n_in    (rst_n_in),
    .load_in     (load_pulse),
    .load_val_in (adv_dflt),
    .wr_in       (wr_adv),
    .wr_data_in  (pwdata_in[ADV_W-1:0]),
    .q_out       (adv_q)
  );

  p2s_cfg_reg #(.W(EEE_W), .RST(EEE_RST), .WMASK(EEE_WMASK)) u_eee (
    .ref_clk_in  (ref_clk_in),
    .rst_n_in    (rst_n_in),
    .load_in     (load_pulse),
    .load_val_in (eee_dflt),
    .wr_in       (wr_eee),
    .wr_data_in  (pwdata_in[EEE_W-1:0]),
    .q_out       (eee_q)
  );

  // outputs re-registered
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      flow_out_r <= '0;
    end else begin
      flow_out_r.backpressure_enable <= flow_q[FLOW_BP_POS];
      flow_out_r.tx_pause_enable     <= flow_q[FLOW_TX_POS];
      flow_out_r.rx_pause_enable     <= flow_q[FLOW_RX_POS];
      flow_out_r.manual_pause_ctrl   <= flow_q[FLOW_MAN_POS];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      mac_out_r <= 1'b0;
    end else begin
      mac_out_r <= mac_q[MAC_EEE_POS];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      adv_out_r <= '0;
    end else begin
      adv_out_r.sym_pause  <= adv_q[ADV_SYM_POS];
      adv_out_r.asym_pause <= adv_q[ADV_ASYM_POS];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      eee_out_r <= '0;
    end else begin
      eee_out_r.enable     <= eee_q[EEE_EN_POS];
      eee_out_r.capability <= eee_q[EEE_CAP_POS];
      eee_out_r.advertise  <= eee_q[EEE_ADV_POS];
    end
  end

  assign pready_out                      = pready_r;
  assign pslverr_out                     = pslverr_r;
  assign prdata_out                      = prdata_r;
  assign port2_flow_out                  = flow_out_r;
  assign mac_energy_efficient_enable_out = mac_out_r;
  assign phy_autoneg_advertise_out       = adv_out_r;
  assign phy_energy_efficient_out        = eee_out_r;
  assign straps_loaded_out               = loaded_r;

endmodule // p2s_top

// *** bench/p2s_strap_src.sv ***
// strap source model for the port 2 strap default block
// assumes cfg_in is set before reset release
module p2s_strap_src (
  input  wire logic           ref_clk_in,
  input  wire logic           rst_n_in,
  input  wire logic [4:0]     cfg_in,
  output p2s_pkg::p2s_straps_t straps_out,
  output logic                pin_out,
  output logic                fiber_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import p2s_pkg::*;
  logic [2:0] hold_r;
  logic [4:0] lvl;
  // pins hold for four edges after release, then are reused
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      hold_r <= 3'h0;
    end else if (hold_r != 3'h4) begin
      hold_r <= hold_r + 3'h1;
    end
  end
  assign lvl = (hold_r == 3'h4) ? ~cfg_in : cfg_in;
  assign straps_out = '{backpressure: lvl[0], fullduplex_pause: lvl[1], manual_pause: lvl[2]};
  assign pin_out = lvl[3];
  assign fiber_out = lvl[4];
endmodule // p2s_strap_src

// *** bench/p2s_top_monitor.sv ***
// checker for the port 2 strap default block
// assumes it is bound to p2s_top and sees its ports only
module p2s_top_monitor (
  input wire logic                      ref_clk_in,
  input wire logic                      rst_n_in,
  input wire p2s_pkg::p2s_straps_t      straps_in,
  input wire logic                      energy_efficient_enable_pin_in,
  input wire logic                      phy_b_fiber_mode_in,
  input wire logic                      psel_in,
  input wire logic                      penable_in,
  input wire logic                      pready_out,
  input wire p2s_pkg::p2s_flow_t        port2_flow_out,
  input wire logic                      mac_energy_efficient_enable_out,
  input wire p2s_pkg::p2s_phy_adv_t     phy_autoneg_advertise_out,
  input wire p2s_pkg::p2s_phy_eee_t     phy_energy_efficient_out,
  input wire logic                      straps_loaded_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import p2s_pkg::*;
  p2s_straps_t s_r;
  logic        pin_r;
  logic        fib_r;
  logic        eee;
  logic        fd_tp;
  // copy of the straps at the load edge
  always_ff @(posedge ref_clk_in) begin
    if (rst_n_in && !straps_loaded_out) begin
      s_r   <= straps_in;
      pin_r <= energy_efficient_enable_pin_in;
      fib_r <= phy_b_fiber_mode_in;
    end
  end
  assign eee = pin_r & ~fib_r;
  assign fd_tp = s_r.fullduplex_pause & ~fib_r;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_bp_default: assert property (
    $rose(straps_loaded_out) |=> port2_flow_out.backpressure_enable == s_r.backpressure)
    else $error("backpressure default wrong");
  chk_fd_pause: assert property ($rose(straps_loaded_out) |=>
    {port2_flow_out.tx_pause_enable, port2_flow_out.rx_pause_enable} == {2{s_r.fullduplex_pause}})
    else $error("pause enable defaults wrong");
  chk_manual_sel: assert property (
    $rose(straps_loaded_out) |=> port2_flow_out.manual_pause_ctrl == s_r.manual_pause)
    else $error("manual pause default wrong");
  chk_asym_adv: assert property (
    $rose(straps_loaded_out) |=> phy_autoneg_advertise_out.asym_pause == (fd_tp & ~s_r.manual_pause))
    else $error("asymmetric pause default wrong");
  chk_sym_adv: assert property (
    $rose(straps_loaded_out) |=> phy_autoneg_advertise_out.sym_pause == fd_tp)
    else $error("symmetric pause default wrong");
  chk_mac_eee: assert property (
    $rose(straps_loaded_out) |=> mac_energy_efficient_enable_out == eee)
    else $error("mac eee default wrong");
  chk_phy_eee: assert property (
    $rose(straps_loaded_out) |=> phy_energy_efficient_out == {3{eee}})
    else $error("phy eee defaults wrong");
  chk_load_time: assert property (
    $rose(rst_n_in) |=> straps_loaded_out ##1 straps_loaded_out)
    else $error("straps not loaded in time");
  chk_ready_pulse: assert property (
    psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
    else $error("ready not a single pulse");
endmodule // p2s_top_monitor
bind p2s_top p2s_top_monitor i_p2s_top_monitor (
  .ref_clk_in, .rst_n_in, .straps_in, .energy_efficient_enable_pin_in, .phy_b_fiber_mode_in,
  .psel_in, .penable_in, .pready_out, .port2_flow_out, .mac_energy_efficient_enable_out,
  .phy_autoneg_advertise_out, .phy_energy_efficient_out, .straps_loaded_out
);

// *** bench/tb_p2s_top.sv ***
// testbench for the port 2 strap default block
// assumes p2s_top with its bound checker and the strap source model
module tb_p2s_top;
  timeunit 1ns;
  timeprecision 100ps;
  import p2s_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pin, fiber, mac_eee, loaded, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, r, d;
  logic [4:0] cfg, c;
  p2s_straps_t straps;
  p2s_flow_t flow;
  p2s_phy_adv_t adv;
  p2s_phy_eee_t eee_o;
  int n_fail, n_compared, cyc;
  p2s_strap_src i_p2s_strap_src (.ref_clk_in(clk), .rst_n_in(rst_n), .cfg_in(cfg),
    .straps_out(straps), .pin_out(pin), .fiber_out(fiber));
  p2s_top i_p2s_top (.ref_clk_in(clk), .rst_n_in(rst_n), .straps_in(straps),
    .energy_efficient_enable_pin_in(pin), .phy_b_fiber_mode_in(fiber), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata), .port2_flow_out(flow),
    .mac_energy_efficient_enable_out(mac_eee), .phy_autoneg_advertise_out(adv),
    .phy_energy_efficient_out(eee_o), .straps_loaded_out(loaded));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // c: bit0 bp, 1 fd, 2 manual, 3 eee pin, 4 fiber
  function automatic logic [31:0] exp_reg(input logic [4:0] cv, input int k);
    logic pe;
    logic fd;
    pe = cv[3] & ~cv[4];
    fd = cv[1] & ~cv[4];
    case (k)
      0: return {26'h0, 1'b1, cv};
      1: return {28'h0, cv[2], cv[1], cv[1], cv[0]};
      2: return {31'h0, pe};
      3: return {30'h0, fd & ~cv[2], fd};
      default: return {29'h0, {3{pe}}};
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      n_fail++;
      $display("FAIL at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {n_fail, n_compared, cyc} = '0;
    cfg = 5'h0b;
    seed = 32'h0000_2bcf;
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      c = (i == 0) ? 5'h0b : (i == 1) ? 5'h1f : (i == 2) ? 5'h04 : seed[4:0];
      @(posedge clk);
      rst_n <= 1'b0;
      cfg <= c;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk({28'h0, flow}, exp_reg(c, 1));
      chk({31'h0, mac_eee}, exp_reg(c, 2));
      chk({30'h0, adv}, exp_reg(c, 3));
      chk({29'h0, eee_o}, exp_reg(c, 4));
      apb(1'b1, 8'h00, seed);
      chk({31'h0, e}, 32'h1);
      apb(1'b0, 8'h14, 32'h0);
      chk({e, r[30:0]}, 32'h8000_0000);
      for (int k = 0; k < 5; k++) begin
        apb(1'b0, 8'(4 * k), 32'h0);
        chk(r, exp_reg(c, k));
      end
      d = xs(seed);
      apb(1'b1, 8'h04, d);
      apb(1'b1, 8'h10, d);
      apb(1'b0, 8'h04, 32'h0);
      chk(r, {28'h0, d[3:0]});
      chk({28'h0, flow}, {28'h0, d[3:0]});
      apb(1'b0, 8'h10, 32'h0);
      chk(r, {29'h0, d[2], c[3] & ~c[4], d[0]});
      apb(1'b1, 8'h08, ~d);
      apb(1'b1, 8'h0C, ~d);
      apb(1'b0, 8'h08, 32'h0);
      chk(r, {31'h0, ~d[0]});
      chk({31'h0, mac_eee}, {31'h0, ~d[0]});
      apb(1'b0, 8'h0C, 32'h0);
      chk(r, {30'h0, ~d[1:0]});
      chk({30'h0, adv}, {30'h0, ~d[1:0]});
    end
    give_verdict();
  end
endmodule // tb_p2s_top
